//--- rtl/pwm_timebase_pkg.sv
// Purpose: constants for the multichannel pwm timebase block
// Assumes: 200 MHz system clock, generic clock made by a divider
// Notes:   register byte offsets on an axi4-lite slave
// Operation
// R1: enabled count starts at zero, steps per generic tick, wraps after top.
// R2: spread zero makes the top field the effective top value.
// R3: generic clock first, then the enable bit starts operation.
// R4: timebase clear bit resets the count at once; outputs may glitch.
// R5: timebase clear also resets spread counter and effective top value.
// R6: nonzero spread runs a signed counter from minus range up to range.
// R7: effective top value is top plus the current spread count.
// R8: spread counter advances by one on every timebase wrap.
// R9: spread range is clamped so effective top never exceeds 0xff.
// R10: spread range is clamped so effective top never goes below zero.
// R11: reading spread returns exactly the value software wrote.
// R12: each channel duty value is write-only; reads never return it.
// R13: output low when duty zero or count above duty, else high.
// R14: single-value mode loads one duty into any selected channel set.
// R15: multi-value mode loads four byte duties into four selected channels.
// R16: duty changes are synchronised so outputs never glitch.
// R17: alternate channels switch half a generic period later than others; here odd channels lag even ones by one system clock.
// R18: pairing register zero sends each waveform straight to its output.
// R19: paired even output is xor of both, odd is its inverse.
// R20: pairing bit zero serves the lowest pair, upward from there.
// R21: block keeps running while the processor is halted for debug.
// R22: gated clocks halt the block; it resumes from preserved state.
// R23: software disables the block before stopping its bus clock.
// R24: register writes arriving while busy is set are discarded.
// R25: duties apply only at top; busy stays set until then; while disabled the code applies them and clears busy at once.
// R26: multi-value ignores absent channels; highest selector field wins.
// R27: each wrap sets the overflow flag; masked flag raises interrupt.
package pwm_timebase_pkg;
  localparam int NUM_CH   = 8;
  localparam int NUM_PAIR = NUM_CH / 2;
  localparam int NUM_SEL  = 4;

  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_SGL_DUTY  = 8'h04;
  localparam logic [7:0] OFF_MUL_DUTY  = 8'h08;
  localparam logic [7:0] OFF_MUL_SEL   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h10;
  localparam logic [7:0] OFF_IRQ_DIS   = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1c;
  localparam logic [7:0] OFF_STAT_CLR  = 8'h20;
  localparam logic [7:0] OFF_PARAM     = 8'h24;
  localparam logic [7:0] OFF_VERSION   = 8'h28;
  localparam logic [7:0] OFF_TOP       = 8'h2c;
  localparam logic [7:0] OFF_SGL_SET   = 8'h30;
  localparam logic [7:0] OFF_PAIRING   = 8'h40;

  localparam int CTL_EN_BIT     = 0;
  localparam int CTL_CLEAR_BIT  = 1;
  localparam int CTL_SPREAD_LSB = 8;
  localparam int ST_OVF_BIT     = 0;
  localparam int ST_READY_BIT   = 1;
  localparam int ST_BUSY_BIT    = 2;
  localparam int BYTE_W         = 8;

  localparam logic [7:0]  COUNT_MAX   = 8'hff;
  localparam logic [31:0] PARAM_VAL   = 32'h0000_0008;
  // version value is arbitrary
  localparam logic [31:0] VERSION_VAL = 32'h0000_0100;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam int SYS_PERIOD_PS = 5000;
  localparam int GEN_PERIOD_PS = 20000;
  localparam int GEN_DIV  = GEN_PERIOD_PS / SYS_PERIOD_PS;
  localparam logic [3:0] DIV_LAST = 4'(GEN_DIV - 1);
  localparam logic [3:0] DIV_HALF = 4'(GEN_DIV / 2 - 1);
endpackage

//--- rtl/multichannel_pwm_timebase.sv
// Purpose: pwm generator with shared timebase and spread spectrum top
// Assumes: generic clock is a tick enable derived from clk_sys_in
// Notes:   axi4-lite register slave; one write and one read in flight
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module multichannel_pwm_timebase
  import pwm_timebase_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               reset_n_in,
  input  wire logic [7:0]         s_axi_awaddr_in,
  input  wire logic               s_axi_awvalid_in,
  output logic                    s_axi_awready_out,
  input  wire logic [31:0]        s_axi_wdata_in,
  input  wire logic [3:0]         s_axi_wstrb_in,
  input  wire logic               s_axi_wvalid_in,
  output logic                    s_axi_wready_out,
  output logic [1:0]              s_axi_bresp_out,
  output logic                    s_axi_bvalid_out,
  input  wire logic               s_axi_bready_in,
  input  wire logic [7:0]         s_axi_araddr_in,
  input  wire logic               s_axi_arvalid_in,
  output logic                    s_axi_arready_out,
  output logic [31:0]             s_axi_rdata_out,
  output logic [1:0]              s_axi_rresp_out,
  output logic                    s_axi_rvalid_out,
  input  wire logic               s_axi_rready_in,
  output logic [NUM_CH-1:0]       channel_wave_out,
  output logic [NUM_CH-1:0]       channel_wave_out_open_drain_out,
  output logic [NUM_CH-1:0]       channel_wave_od_oe_n_out,
  output logic                    irq_out
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFF_CONTROL) | hit(a, OFF_SGL_DUTY) |
             hit(a, OFF_MUL_DUTY) | hit(a, OFF_MUL_SEL) |
             hit(a, OFF_IRQ_EN) | hit(a, OFF_IRQ_DIS) |
             hit(a, OFF_IRQ_MASK) | hit(a, OFF_STATUS) |
             hit(a, OFF_STAT_CLR) | hit(a, OFF_PARAM) |
             hit(a, OFF_VERSION) | hit(a, OFF_TOP) |
             hit(a, OFF_SGL_SET) | hit(a, OFF_PAIRING);
  endfunction

  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  // bus side state
  logic        aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        arready_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  // configuration and status
  logic                en_ff;
  logic [7:0]          spread_ff, top_ff, sgl_duty_ff;
  logic [31:0]         mul_duty_ff;
  logic [NUM_PAIR-1:0] pairing_ff;
  logic [1:0]          irq_mask_ff;
  logic                ovf_ff, busy_ff, irq_ff;
  // timebase and channels
  logic [3:0]          div_ff;
  logic [7:0]          count_ff;
  logic signed [8:0]   spread_cnt_ff;
  logic [7:0]          duty_ff [NUM_CH];
  logic [7:0]          pend_duty_ff [NUM_CH];
  logic [NUM_CH-1:0]   pend_mask_ff, wave_ff, out_ff, oe_n_ff;

  // write and read channel handshake
  wire aw_take  = s_axi_awvalid_in & awready_ff;
  wire w_take   = s_axi_wvalid_in & wready_ff;
  wire wr_fire  = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire nxt_aw_held = ~wr_fire & (aw_held_ff | aw_take);
  wire nxt_w_held  = ~wr_fire & (w_held_ff | w_take);
  wire nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready_in);
  wire ar_take  = s_axi_arvalid_in & arready_ff;
  wire nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready_in);

  // write decode; a busy block drops every write but still answers
  wire [7:0] wa    = aw_addr_ff;
  wire       wr_en = wr_fire & ~busy_ff;                    // [R24]
  wire wr_ctl      = wr_en & hit(wa, OFF_CONTROL);
  wire wr_sgl_duty = wr_en & hit(wa, OFF_SGL_DUTY) & w_strb_ff[0];
  wire wr_mul_duty = wr_en & hit(wa, OFF_MUL_DUTY);
  wire wr_mul_sel  = wr_en & hit(wa, OFF_MUL_SEL);
  wire wr_irq_en   = wr_en & hit(wa, OFF_IRQ_EN) & w_strb_ff[0];
  wire wr_irq_dis  = wr_en & hit(wa, OFF_IRQ_DIS) & w_strb_ff[0];
  wire wr_stat_clr = wr_en & hit(wa, OFF_STAT_CLR) & w_strb_ff[0];
  wire wr_top      = wr_en & hit(wa, OFF_TOP) & w_strb_ff[0];
  wire wr_sgl_set  = wr_en & hit(wa, OFF_SGL_SET);
  wire wr_pairing  = wr_en & hit(wa, OFF_PAIRING) & w_strb_ff[0];
  wire ctl_lo      = wr_ctl & w_strb_ff[0];
  wire clr = ctl_lo & w_data_ff[CTL_CLEAR_BIT];             // [R4]

  // generic clock ticks: rising at tick, falling at half
  wire tick = (div_ff == DIV_LAST);
  wire half = (div_ff == DIV_HALF);

  // clamp the range so top +/- range stays inside 0..0xff  [R9] [R10]
  wire [7:0] range = min8(spread_ff, min8(COUNT_MAX - top_ff, top_ff));
  wire signed [8:0] neg_range = -$signed({1'b0, range});
  wire signed [9:0] etv_sum = $signed({2'b00, top_ff}) +
                              ((range == 8'h00) ? 10'sh000 :
                               10'(spread_cnt_ff));          // [R2] [R7]
  wire [7:0] effective_top_value = etv_sum[9] ? 8'h00 :
                   (etv_sum[8] ? COUNT_MAX : etv_sum[7:0]);
  wire at_top = (count_ff >= effective_top_value);
  wire wrap   = en_ff & tick & at_top & ~clr;
  wire spread_last = (spread_cnt_ff >= $signed({1'b0, range}));

  // pending duties reach the channels only at top, or at once if stopped
  wire apply = busy_ff & (wrap | ~en_ff);                    // [R25] [R16]
  wire [2:0] status = {busy_ff, ~busy_ff, ovf_ff};

  logic [7:0]        nxt_pend_duty [NUM_CH];
  logic [NUM_CH-1:0] nxt_pend_mask;
  logic [NUM_CH-1:0] raw_wave, nxt_out;

  always_comb begin
    nxt_pend_mask = apply ? '0 : pend_mask_ff;
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_pend_duty[i] = pend_duty_ff[i];
      if (wr_sgl_set && w_data_ff[i]) begin                 // [R14]
        nxt_pend_duty[i] = sgl_duty_ff;
        nxt_pend_mask[i] = 1'b1;
      end
    end
    // later selector fields overwrite earlier ones          [R26]
    for (int k = 0; k < NUM_SEL; k++) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_mul_sel && w_data_ff[k*BYTE_W +: BYTE_W] == 8'(i)) begin
          nxt_pend_duty[i] = mul_duty_ff[k*BYTE_W +: BYTE_W]; // [R15]
          nxt_pend_mask[i] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      raw_wave[i] = en_ff & (duty_ff[i] != 8'h00) &
                    (count_ff <= duty_ff[i]);                // [R13]
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      // pair p covers channels 2p and 2p+1                  [R20]
      if (pairing_ff[p]) begin
        nxt_out[2*p]   = wave_ff[2*p] ^ wave_ff[2*p+1];      // [R19]
        nxt_out[2*p+1] = ~(wave_ff[2*p] ^ wave_ff[2*p+1]);
      end else begin
        nxt_out[2*p]   = wave_ff[2*p];                       // [R18]
        nxt_out[2*p+1] = wave_ff[2*p+1];
      end
    end
  end

  wire [31:0] rd_val =
    hit(s_axi_araddr_in, OFF_CONTROL) ?
      {16'h0000, spread_ff, 7'h00, en_ff} :                  // [R11]
    hit(s_axi_araddr_in, OFF_IRQ_MASK) ? {30'h0, irq_mask_ff} :
    hit(s_axi_araddr_in, OFF_STATUS)   ? {29'h0, status} :
    hit(s_axi_araddr_in, OFF_PARAM)    ? PARAM_VAL :
    hit(s_axi_araddr_in, OFF_VERSION)  ? VERSION_VAL :
    hit(s_axi_araddr_in, OFF_TOP)      ? {24'h0, top_ff} :
    hit(s_axi_araddr_in, OFF_PAIRING)  ? 32'(pairing_ff) :
    32'h0000_0000;                     // duty registers read zero [R12]

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held;
      wready_ff  <= ~nxt_w_held;
      bvalid_ff  <= nxt_bvalid;
      if (aw_take) aw_addr_ff <= s_axi_awaddr_in;
      if (w_take) begin
        w_data_ff <= s_axi_wdata_in;
        w_strb_ff <= s_axi_wstrb_in;
      end
      if (wr_fire) bresp_ff <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_val;
        rresp_ff <= mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      en_ff       <= 1'b0;
      spread_ff   <= 8'h00;
      top_ff      <= 8'h00;
      sgl_duty_ff <= 8'h00;
      mul_duty_ff <= 32'h0000_0000;
      pairing_ff  <= '0;
      irq_mask_ff <= 2'h0;
    end else begin
      if (ctl_lo) en_ff <= w_data_ff[CTL_EN_BIT];           // [R3]
      if (wr_ctl && w_strb_ff[1]) begin
        spread_ff <= w_data_ff[CTL_SPREAD_LSB +: BYTE_W];   // [R11]
      end
      if (wr_top) top_ff <= w_data_ff[7:0];
      if (wr_sgl_duty) sgl_duty_ff <= w_data_ff[7:0];
      if (wr_mul_duty) mul_duty_ff <= w_data_ff;
      if (wr_pairing) pairing_ff <= w_data_ff[NUM_PAIR-1:0];
      if (wr_irq_en) irq_mask_ff <= irq_mask_ff | w_data_ff[1:0];
      else if (wr_irq_dis) irq_mask_ff <= irq_mask_ff & ~w_data_ff[1:0];
    end
  end

  // one system clock drives all of it, so a debug halt elsewhere does not
  // stop it, and a gated clock freezes every flop in place  [R21] [R22]
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      div_ff        <= 4'h0;
      count_ff      <= 8'h00;
      spread_cnt_ff <= 9'sh000;
    end else begin
      div_ff <= tick ? 4'h0 : div_ff + 4'h1;
      if (!en_ff || clr) begin                               // [R1] [R5]
        count_ff      <= 8'h00;
        spread_cnt_ff <= neg_range;                          // [R6]
      end else if (tick) begin
        if (at_top) begin
          count_ff      <= 8'h00;                            // [R1]
          spread_cnt_ff <= spread_last ? neg_range :
                           spread_cnt_ff + 9'sh001;          // [R8]
        end else begin
          count_ff <= count_ff + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      busy_ff      <= 1'b0;
      pend_mask_ff <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_ff[i]      <= 8'h00;
        pend_duty_ff[i] <= 8'h00;
      end
    end else begin
      busy_ff      <= (busy_ff & ~apply) | wr_sgl_set | wr_mul_sel;
      pend_mask_ff <= nxt_pend_mask;
      for (int i = 0; i < NUM_CH; i++) begin
        pend_duty_ff[i] <= nxt_pend_duty[i];
        if (apply && pend_mask_ff[i]) duty_ff[i] <= pend_duty_ff[i];
      end
    end
  end

  // odd channels move one system clock, a quarter generic period, late to spread pin edges
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      wave_ff  <= '0;
      out_ff   <= '0;
      oe_n_ff  <= '1;
      ovf_ff   <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (i % 2 == 0 || half) wave_ff[i] <= raw_wave[i];  // [R17]
      end
      out_ff  <= nxt_out;
      oe_n_ff <= nxt_out;          // drive the open drain pin only low
      // a wrap in the clearing cycle still leaves the flag set
      ovf_ff  <= wrap | (ovf_ff & ~(wr_stat_clr &
                 w_data_ff[ST_OVF_BIT]));                    // [R27]
      irq_ff  <= (ovf_ff & irq_mask_ff[ST_OVF_BIT]) |
                 (~busy_ff & irq_mask_ff[ST_READY_BIT]);
    end
  end

  assign s_axi_awready_out  = awready_ff;
  assign s_axi_wready_out   = wready_ff;
  assign s_axi_bvalid_out   = bvalid_ff;
  assign s_axi_bresp_out    = bresp_ff;
  assign s_axi_arready_out  = arready_ff;
  assign s_axi_rvalid_out   = rvalid_ff;
  assign s_axi_rdata_out    = rdata_ff;
  assign s_axi_rresp_out    = rresp_ff;
  assign channel_wave_out   = out_ff;
  assign channel_wave_od_oe_n_out = oe_n_ff;
  assign channel_wave_out_open_drain_out = '0;
  assign irq_out            = irq_ff;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  count_wrap_a: assert property (wrap |=> count_ff == 8'h00) // [R1]
    else $error("count did not wrap at effective top");
  count_step_a: assert property (                              // [R1]
    en_ff && tick && !at_top && !clr |=>
    count_ff == $past(count_ff) + 8'h01)
    else $error("count did not step on a generic tick");
  etv_direct_a: assert property (spread_ff == 8'h00 |-> effective_top_value == top_ff) // [R2]
    else $error("zero spread must give top as effective top");
  clear_reset_a: assert property (                             // [R5]
    clr |=> count_ff == 8'h00 && spread_cnt_ff == $past(neg_range))
    else $error("clear did not reset the counters");
  spread_read_a: assert property (                             // [R11]
    wr_ctl && w_strb_ff[1] ##1 ar_take &&
    hit(s_axi_araddr_in, OFF_CONTROL) && !wr_ctl |=>
    s_axi_rdata_out[15:8] == $past(w_data_ff[15:8], 2))
    else $error("spread readback differs from written value");
  duty_zero_a: assert property (                               // [R13]
    (duty_ff[0] == 8'h00 && !pairing_ff[0])[*3] |->
    !channel_wave_out[0])
    else $error("zero duty must give a low output");
  busy_hold_a: assert property (busy_ff && !apply |=> busy_ff) // [R25]
    else $error("busy dropped before duties applied");
  apply_load_a: assert property (                              // [R25]
    apply && pend_mask_ff[0] |=> !busy_ff &&
    duty_ff[0] == $past(pend_duty_ff[0]))
    else $error("pending duty not loaded at top");
  discard_a: assert property (                                 // [R24]
    wr_fire && busy_ff && !apply |=>
    pend_mask_ff == $past(pend_mask_ff) && busy_ff)
    else $error("write accepted while busy");
  ovf_set_a: assert property (wrap |=> ovf_ff)                 // [R27]
    else $error("overflow flag not set on wrap");
  pair_inv_a: assert property (                                // [R19]
    pairing_ff[0] && $past(pairing_ff[0]) |->
    channel_wave_out[0] != channel_wave_out[1])
    else $error("paired outputs are not complementary");

  spread_wrap_c: cover property (wrap && range != 8'h00 && spread_last);
  apply_c:       cover property (apply && en_ff);
  multi_sel_c:   cover property (wr_mul_sel);
  pair_c:        cover property (pairing_ff[0] && channel_wave_out[0]);
endmodule

//--- sim/pin_load_model.sv
// Purpose: pin loads seen by the pwm outputs
// Assumes: open-drain lines carry an external pull-up
// Notes:   push-pull pins simply follow the driven waveform
`timescale 1ns/100ps
module pin_load_model
  import pwm_timebase_pkg::*;
(
  input  wire logic [NUM_CH-1:0] wave_in,
  input  wire logic [NUM_CH-1:0] od_data_in,
  input  wire logic [NUM_CH-1:0] od_oe_n_in,
  output logic      [NUM_CH-1:0] pin_level_out,
  output logic      [NUM_CH-1:0] od_pin_out
);
  assign pin_level_out = wave_in;
  // a released line is lifted by the pull-up, never left at its last value
  assign od_pin_out = od_data_in | od_oe_n_in;
endmodule

//--- sim/multichannel_pwm_timebase_bench.sv
// Purpose: self-checking bench for the multichannel pwm timebase
// Assumes: generic tick every 4 system clocks, 8 channels
// Notes:   high times are counted over whole periods, so phase is free
`timescale 1ns/100ps
module multichannel_pwm_timebase_bench;
  import pwm_timebase_pkg::*;
  logic              clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [NUM_CH-1:0] wave, od_data, oe_n, pin, od_pin;
  int                num_errors, checks;

  multichannel_pwm_timebase multichannel_pwm_timebase_i (
    .clk_sys_in(clk), .reset_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .channel_wave_out(wave),
    .channel_wave_out_open_drain_out(od_data),
    .channel_wave_od_oe_n_out(oe_n), .irq_out(irq));

  pin_load_model pin_load_model_i (.wave_in(wave), .od_data_in(od_data),
    .od_oe_n_in(oe_n), .pin_level_out(pin), .od_pin_out(od_pin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task stop_test;
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask

  task timeout;
    num_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    stop_test;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 100) timeout;
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 100) timeout;
    d = rdata;
    rready <= 1'b0;
  endtask

  // duty loads land only at a wrap while enabled, so wait for busy to drop
  task automatic idle;
    logic [31:0] s;
    for (int n = 0; n < 300; n++) begin
      rd(OFF_STATUS, s);
      if (s[ST_BUSY_BIT] === 1'b0) return;
    end
    timeout;
  endtask

  task automatic measure(input int ch, input int n, output int hi,
                         output int rises);
    logic prev;
    int   odd;
    hi = 0;
    rises = 0;
    odd = 0;
    @(posedge clk);
    prev = pin[ch];
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      hi += (pin[ch] === 1'b1);
      rises += (pin[ch] === 1'b1 && prev === 1'b0);
      odd += (od_pin[ch] !== pin[ch]);
      prev = pin[ch];
    end
    chk(odd, 0, "open-drain pin");
  endtask

  task automatic hi_is(input int ch, input int exp);
    int h, r;
    measure(ch, 64, h, r);
    chk(h, exp, "high cycles");
  endtask

  task s_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFF_CONTROL, d);
    chk(d, 0, "control reset");
    wr(8'hfc, 32'h1, r);
    chk(r, RESP_SLVERR, "unmapped write");
    rd(8'hfc, d);
    chk(d, 0, "unmapped read");
    w(OFF_SGL_DUTY, 32'h5a);
    rd(OFF_SGL_DUTY, d);
    chk(d, 32'h0, "duty reads zero");
    w(OFF_TOP, 32'h3);
    rd(OFF_TOP, d);
    chk(d[7:0], 3, "top");
  endtask

  task s_single;
    logic [31:0] d;
    logic [1:0]  r;
    int          h, ri;
    w(OFF_SGL_DUTY, 32'h2);
    w(OFF_CONTROL, 32'h1 << CTL_EN_BIT);
    w(OFF_SGL_SET, 32'h1);
    wr(OFF_TOP, 32'h7, r);
    chk(r, RESP_OKAY, "busy write answer");
    idle;
    rd(OFF_TOP, d);
    chk(d[7:0], 3, "busy write kept out");
    measure(0, 64, h, ri);
    chk(h, 48, "duty 2 high");
    chk(ri, 4, "periods");
    hi_is(1, 0);
    w(OFF_SGL_DUTY, 32'h3);
    w(OFF_SGL_SET, 32'h2);
    idle;
    hi_is(1, 64);
    hi_is(0, 48);
  endtask

  task s_multi;
    w(OFF_MUL_DUTY, 32'h0003_0201);
    w(OFF_MUL_SEL, 32'h0902_0204);
    idle;
    hi_is(4, 32);
    hi_is(2, 64);
    hi_is(1, 64);
    hi_is(3, 0);
    hi_is(0, 48);
  endtask

  task s_pair;
    w(OFF_PAIRING, 32'h3);
    hi_is(0, 16);
    hi_is(1, 48);
    hi_is(2, 64);
    hi_is(3, 0);
    w(OFF_PAIRING, 32'h0);
    hi_is(0, 48);
  endtask

  // top 250 with spread 10 must clamp to a range of 5: tops 245..255
  task s_spread;
    logic [31:0] d;
    int          h, ri;
    w(OFF_TOP, 32'd250);
    w(OFF_CONTROL, (32'd10 << CTL_SPREAD_LSB) | 32'h1);
    rd(OFF_CONTROL, d);
    chk(d[15:8], 10, "spread readback");
    repeat (1100) @(posedge clk);
    measure(0, 11044, h, ri);
    chk(ri, 11, "spread periods");
    chk(h, 132, "spread high");
    // clear restarts the count, so duty 2 shows 9 to 12 clocks of high soon
    w(OFF_CONTROL, (32'd10 << CTL_SPREAD_LSB) |
      (32'h1 << CTL_CLEAR_BIT) | 32'h1);
    measure(0, 64, h, ri);
    chk(h >= 9 && h <= 12, 1, "clear restart");
  endtask

  task s_irq;
    logic [31:0] d;
    int          n;
    w(OFF_IRQ_EN, 32'h1);
    rd(OFF_IRQ_MASK, d);
    chk(d[0], 1, "mask set");
    for (n = 0; n < 1100 && irq !== 1'b1; n++) @(posedge clk);
    if (n == 1100) timeout;
    chk(irq, 1, "overflow irq");
    rd(OFF_STATUS, d);
    chk(d[ST_OVF_BIT], 1, "overflow flag");
    w(OFF_IRQ_DIS, 32'h1);
    w(OFF_STAT_CLR, 32'h1);
    chk(irq, 0, "irq masked");
    // ready interrupt: nothing pending, so it fires once unmasked
    w(OFF_IRQ_EN, 32'h2);
    @(posedge clk);
    chk(irq, 1, "ready irq");
    w(OFF_IRQ_DIS, 32'h2);
  endtask

  task s_off;
    w(OFF_CONTROL, 32'h0);
    repeat (8) @(posedge clk);
    hi_is(0, 0);
  endtask

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    num_errors = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_regs;
    s_single;
    s_multi;
    s_pair;
    s_spread;
    s_irq;
    s_off;
    stop_test;
  end
endmodule
